// >>> design/codc_pkg.sv
package codc_pkg;

  // byte-wide configuration space reached by the serial configuration engine
  typedef logic [15:0] codc_addr_t;
  typedef logic [2:0]  codc_mode_t;

  localparam int NUM_PAIRS = 4;
  localparam int CMOS_PAIR = 3;

  // register byte addresses
  localparam codc_addr_t ADR_OUT_EN   = 16'h0039;
  localparam codc_addr_t ADR_POL      = 16'h003A;
  localparam codc_addr_t ADR_MODE32   = 16'h003D;
  localparam codc_addr_t ADR_MODE10   = 16'h003E;
  localparam codc_addr_t ADR_DIV0     = 16'h003F;
  localparam codc_addr_t ADR_DIV1     = 16'h0042;
  localparam codc_addr_t ADR_DIV2     = 16'h0045;
  localparam codc_addr_t ADR_DIV3_HI  = 16'h0048;
  localparam codc_addr_t ADR_DIV3_MID = 16'h0049;
  localparam codc_addr_t ADR_DIV3_LO  = 16'h004A;
  localparam codc_addr_t ADR_RSVD_A   = 16'h003B;
  localparam codc_addr_t ADR_RSVD_B   = 16'h0040;

  // field positions inside the bytes
  localparam int EN_LSB      = 0;
  localparam int EN_W        = 4;
  localparam int POL_BIT     = 3;
  localparam int MODE_HI_LSB = 5;
  localparam int SE_BIT      = 4;
  localparam int MODE_LO_LSB = 1;
  localparam int MODE_W      = 3;
  localparam int DIV3_HI_W   = 2;
  localparam int DIV3_W      = 18;
  localparam int DIV3_MID    = 8;
  localparam int BYTE_W      = 8;

  // reset values
  localparam logic [3:0]        RST_OUT_EN = 4'h0;
  localparam logic              RST_POL    = 1'b0;
  localparam codc_mode_t        RST_MODE   = 3'h1;
  localparam logic              RST_SE     = 1'b0;
  localparam logic [7:0]        RST_DIV_LO = 8'h03;
  localparam logic [DIV3_W-1:0] RST_DIV3   = 18'h2_0002;

  // driver style codes
  localparam codc_mode_t MODE_HIZ  = 3'h0;
  localparam codc_mode_t MODE_PECL = 3'h1;
  localparam codc_mode_t MODE_LVDS = 3'h2;
  localparam codc_mode_t MODE_CMOS = 3'h3;
  localparam codc_mode_t MODE_HCSL = 3'h4;

  // legal divider codes
  localparam logic [7:0]        DIV_DIRECT_MIN = 8'h03;
  localparam logic [7:0]        DIV_DIRECT_MAX = 8'h06;
  localparam logic [7:0]        DIV_EVEN_MIN   = 8'h08;
  localparam logic [7:0]        DIV_EVEN_MAX   = 8'hA0;
  localparam logic [DIV3_W-1:0] DIV3_MIN       = 18'h0_0003;

  // register request from the configuration engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    codc_addr_t addr;
    logic [7:0] wdata;
  } codc_req_s;

  // per-pair driver configuration
  typedef struct packed {
    logic       en;
    codc_mode_t mode;
    logic       pol;
    logic       se_same;
  } codc_pcfg_s;

  // state of one output pin pair
  typedef struct packed {
    logic       true_p;
    logic       comp_p;
    logic       oe;
    codc_mode_t style;
  } codc_pin_s;

  // divide ratios handed to the output dividers
  typedef struct packed {
    logic [7:0]        r0;
    logic [7:0]        r1;
    logic [7:0]        r2;
    logic [DIV3_W:0]   r3;
  } codc_div_s;

endpackage

// >>> design/codc_pair_drv.sv
`timescale 1ns/1ps
module codc_pair_drv #(
  parameter bit CMOS_OK = 1'b0
) (
  input  wire logic                 clk_in,     // system clock
  input  wire logic                 resetn_in,  // async reset, active low
  input  wire codc_pkg::codc_pcfg_s cfg_in,     // pair configuration
  input  wire logic                 lvl_in,     // synchronised source clock level
  output codc_pkg::codc_pin_s       pin_out     // registered pin pair state
);
  import codc_pkg::*;

  typedef struct packed {
    codc_pin_s pin;
  } codc_drv_s;

  codc_drv_s  st_ff;
  codc_drv_s  nxt_st;
  logic       drive;
  logic       lvl;

  // reserved codes and a disabled pair both leave the pins floating
  always_comb begin
    drive = cfg_in.en && (cfg_in.mode == MODE_PECL || cfg_in.mode == MODE_LVDS ||
             cfg_in.mode == MODE_HCSL || (CMOS_OK && cfg_in.mode == MODE_CMOS));
    lvl = lvl_in ^ cfg_in.pol;
    nxt_st = st_ff;
    nxt_st.pin.oe     = drive;
    nxt_st.pin.style  = drive ? cfg_in.mode : MODE_HIZ;
    nxt_st.pin.true_p = drive & lvl;
    // single-ended same-phase only in the cmos style; differential always complements
    if (drive && CMOS_OK && cfg_in.mode == MODE_CMOS && cfg_in.se_same) begin
      nxt_st.pin.comp_p = lvl;
    end else begin
      nxt_st.pin.comp_p = drive & ~lvl;
    end
  end

  // pins come from flops so no decode glitch reaches the receivers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.pin;

endmodule // codc_pair_drv

// >>> design/codc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - per-pair enable, cleared means high impedance
// - pair three polarity bit inverts its clock
// - pair three styles include cmos, reset pecl
// - pairs zero to two lack cmos style
// - pair three single-ended phase: opposite or same
// - reserved bits written zero, read as zero
// - divider bytes mapped, pair three high first
// - low dividers accept only legal codes
// - pair three divider doubles, refuses below three
module codc_top (
  input  wire logic                            CLK_IN,          // 50 MHz system clock
  input  wire logic                            RESETN_IN,       // async reset, active low
  input  wire codc_pkg::codc_req_s             REG_REQ_IN,      // register read/write request
  output logic [7:0]                           REG_RDATA_OUT,   // registered read data
  output logic                                 REG_REFUSED_OUT, // pulse: write refused
  input  wire logic [codc_pkg::NUM_PAIRS-1:0]  SRC_CLK_IN,      // divided clocks, async
  output codc_pkg::codc_pin_s [codc_pkg::NUM_PAIRS-1:0] PAIR_OUT, // pin pair drive
  output codc_pkg::codc_div_s                  DIV_RATIO_OUT    // effective divide ratios
);
  import codc_pkg::*;

  typedef struct packed {
    logic [NUM_PAIRS-1:0]             out_en;
    logic                             pol3;
    codc_mode_t [NUM_PAIRS-1:0]       mode;
    logic                             se_same;
    logic [7:0]                       div0;
    logic [7:0]                       div1;
    logic [7:0]                       div2;
    logic [DIV3_W-1:0]                div3;
    logic [7:0]                       rdata;
    logic                             refused;
    logic [NUM_PAIRS-1:0]             sync1;
    logic [NUM_PAIRS-1:0]             sync2;
  } codc_top_s;

  localparam codc_top_s RST_ST = '{
    out_en:  RST_OUT_EN,
    pol3:    RST_POL,
    mode:    {NUM_PAIRS{RST_MODE}},
    se_same: RST_SE,
    div0:    RST_DIV_LO,
    div1:    RST_DIV_LO,
    div2:    RST_DIV_LO,
    div3:    RST_DIV3,
    rdata:   8'h00,
    refused: 1'b0,
    sync1:   4'h0,
    sync2:   4'h0
  };

  codc_top_s                     st_ff;
  codc_top_s                     nxt_st;
  logic [DIV3_W-1:0]             div3_cand;
  codc_pcfg_s [NUM_PAIRS-1:0]    pcfg;

  // legal codes of the 8-bit dividers: 3..6 direct, even 8..160
  function automatic logic lo_div_ok(input logic [7:0] v);
    lo_div_ok = (v >= DIV_DIRECT_MIN && v <= DIV_DIRECT_MAX) ||
                (v >= DIV_EVEN_MIN && v <= DIV_EVEN_MAX && !v[0]);
  endfunction

  // one write of a low divider byte: keep the old code when the new one is illegal
  function automatic logic [7:0] lo_div_wr(input logic [7:0] old_v, input logic [7:0] new_v);
    lo_div_wr = lo_div_ok(new_v) ? new_v : old_v;
  endfunction

  // candidate value of the 18-bit divider after the pending byte write
  always_comb begin
    div3_cand = st_ff.div3;
    if (REG_REQ_IN.addr == ADR_DIV3_HI) begin
      div3_cand[DIV3_W-1 -: DIV3_HI_W] = REG_REQ_IN.wdata[DIV3_HI_W-1:0];
    end else if (REG_REQ_IN.addr == ADR_DIV3_MID) begin
      div3_cand[DIV3_MID +: BYTE_W] = REG_REQ_IN.wdata;
    end else if (REG_REQ_IN.addr == ADR_DIV3_LO) begin
      div3_cand[0 +: BYTE_W] = REG_REQ_IN.wdata;
    end
  end

  // register writes, read mux and source clock synchronisers
  always_comb begin
    nxt_st = st_ff;
    nxt_st.refused = 1'b0;
    nxt_st.sync1   = SRC_CLK_IN;
    nxt_st.sync2   = st_ff.sync1;
    if (REG_REQ_IN.wr) begin
      // reserved bit positions are dropped, never stored
      if (REG_REQ_IN.addr == ADR_OUT_EN) begin
        nxt_st.out_en = REG_REQ_IN.wdata[EN_LSB +: EN_W];
      end else if (REG_REQ_IN.addr == ADR_POL) begin
        nxt_st.pol3 = REG_REQ_IN.wdata[POL_BIT];
      end else if (REG_REQ_IN.addr == ADR_MODE32) begin
        nxt_st.mode[3] = REG_REQ_IN.wdata[MODE_HI_LSB +: MODE_W];
        nxt_st.se_same = REG_REQ_IN.wdata[SE_BIT];
        nxt_st.mode[2] = REG_REQ_IN.wdata[MODE_LO_LSB +: MODE_W];
      end else if (REG_REQ_IN.addr == ADR_MODE10) begin
        nxt_st.mode[1] = REG_REQ_IN.wdata[MODE_HI_LSB +: MODE_W];
        nxt_st.mode[0] = REG_REQ_IN.wdata[MODE_LO_LSB +: MODE_W];
      end else if (REG_REQ_IN.addr == ADR_DIV0) begin
        nxt_st.div0    = lo_div_wr(st_ff.div0, REG_REQ_IN.wdata);
        nxt_st.refused = !lo_div_ok(REG_REQ_IN.wdata);
      end else if (REG_REQ_IN.addr == ADR_DIV1) begin
        nxt_st.div1    = lo_div_wr(st_ff.div1, REG_REQ_IN.wdata);
        nxt_st.refused = !lo_div_ok(REG_REQ_IN.wdata);
      end else if (REG_REQ_IN.addr == ADR_DIV2) begin
        nxt_st.div2    = lo_div_wr(st_ff.div2, REG_REQ_IN.wdata);
        nxt_st.refused = !lo_div_ok(REG_REQ_IN.wdata);
      end else if (REG_REQ_IN.addr == ADR_DIV3_HI || REG_REQ_IN.addr == ADR_DIV3_MID ||
                   REG_REQ_IN.addr == ADR_DIV3_LO) begin
        // bytewise update: a byte that would leave 0, 1 or 2 is refused whole
        if (div3_cand >= DIV3_MIN) begin
          nxt_st.div3 = div3_cand;
        end else begin
          nxt_st.refused = 1'b1;
        end
      end
    end
    if (REG_REQ_IN.rd) begin
      // reserved positions and unmapped bytes read as zero
      nxt_st.rdata = 8'h00;
      if (REG_REQ_IN.addr == ADR_OUT_EN) begin
        nxt_st.rdata[EN_LSB +: EN_W] = st_ff.out_en;
      end else if (REG_REQ_IN.addr == ADR_POL) begin
        nxt_st.rdata[POL_BIT] = st_ff.pol3;
      end else if (REG_REQ_IN.addr == ADR_MODE32) begin
        nxt_st.rdata[MODE_HI_LSB +: MODE_W] = st_ff.mode[3];
        nxt_st.rdata[SE_BIT]                = st_ff.se_same;
        nxt_st.rdata[MODE_LO_LSB +: MODE_W] = st_ff.mode[2];
      end else if (REG_REQ_IN.addr == ADR_MODE10) begin
        nxt_st.rdata[MODE_HI_LSB +: MODE_W] = st_ff.mode[1];
        nxt_st.rdata[MODE_LO_LSB +: MODE_W] = st_ff.mode[0];
      end else if (REG_REQ_IN.addr == ADR_DIV0) begin
        nxt_st.rdata = st_ff.div0;
      end else if (REG_REQ_IN.addr == ADR_DIV1) begin
        nxt_st.rdata = st_ff.div1;
      end else if (REG_REQ_IN.addr == ADR_DIV2) begin
        nxt_st.rdata = st_ff.div2;
      end else if (REG_REQ_IN.addr == ADR_DIV3_HI) begin
        nxt_st.rdata[DIV3_HI_W-1:0] = st_ff.div3[DIV3_W-1 -: DIV3_HI_W];
      end else if (REG_REQ_IN.addr == ADR_DIV3_MID) begin
        nxt_st.rdata = st_ff.div3[DIV3_MID +: BYTE_W];
      end else if (REG_REQ_IN.addr == ADR_DIV3_LO) begin
        nxt_st.rdata = st_ff.div3[0 +: BYTE_W];
      end
    end
  end

  // single state register for the whole bank
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // per-pair configuration; only pair three has polarity and phase controls
  always_comb begin
    for (int i = 0; i < NUM_PAIRS; i++) begin
      pcfg[i].en      = st_ff.out_en[i];
      pcfg[i].mode    = st_ff.mode[i];
      pcfg[i].pol     = (i == CMOS_PAIR) ? st_ff.pol3 : 1'b0;
      pcfg[i].se_same = (i == CMOS_PAIR) ? st_ff.se_same : 1'b0;
    end
  end

  // pin drivers: pair three alone may take the cmos style
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
    codc_pair_drv #(
      .CMOS_OK   (g == CMOS_PAIR)
    ) u_drv (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .cfg_in    (pcfg[g]),
      .lvl_in    (st_ff.sync2[g]),
      .pin_out   (PAIR_OUT[g])
    );
  end

  // outputs straight from flops; pair three ratio is twice the code
  assign REG_RDATA_OUT    = st_ff.rdata;
  assign REG_REFUSED_OUT  = st_ff.refused;
  assign DIV_RATIO_OUT.r0 = st_ff.div0;
  assign DIV_RATIO_OUT.r1 = st_ff.div1;
  assign DIV_RATIO_OUT.r2 = st_ff.div2;
  assign DIV_RATIO_OUT.r3 = {st_ff.div3, 1'b0};

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  // request shapes that start the multi-step checks
  sequence s_bad_div0_wr;
    REG_REQ_IN.wr && REG_REQ_IN.addr == ADR_DIV0 && !lo_div_ok(REG_REQ_IN.wdata);
  endsequence

  sequence s_hi_wr_ok;
    REG_REQ_IN.wr && REG_REQ_IN.addr == ADR_DIV3_HI && div3_cand >= DIV3_MIN;
  endsequence

  sequence s_rsvd_rd;
    REG_REQ_IN.rd && (REG_REQ_IN.addr == ADR_RSVD_A || REG_REQ_IN.addr == ADR_RSVD_B);
  endsequence

  sequence s_bad_div3_wr;
    REG_REQ_IN.wr && div3_cand < DIV3_MIN && (REG_REQ_IN.addr == ADR_DIV3_HI ||
        REG_REQ_IN.addr == ADR_DIV3_MID || REG_REQ_IN.addr == ADR_DIV3_LO);
  endsequence

  sequence s_en_wr;
    REG_REQ_IN.wr && REG_REQ_IN.addr == ADR_OUT_EN;
  endsequence

  sequence s_pol_wr;
    REG_REQ_IN.wr && REG_REQ_IN.addr == ADR_POL;
  endsequence

  sequence s_mode32_rd;
    REG_REQ_IN.rd && REG_REQ_IN.addr == ADR_MODE32;
  endsequence

  // pin checks, one set per pair
  for (genvar a = 0; a < NUM_PAIRS; a++) begin : g_chk
    pair_off_a: assert property (!st_ff.out_en[a] |=> !PAIR_OUT[a].oe &&
        PAIR_OUT[a].style == MODE_HIZ)
      else $error("disabled pair is driving");
    rsvd_mode_a: assert property (st_ff.mode[a] > MODE_HCSL |=> !PAIR_OUT[a].oe)
      else $error("reserved style code drives the pair");
    pair_drive_a: assert property (st_ff.out_en[a] && st_ff.mode[a] == MODE_PECL
        |=> PAIR_OUT[a].oe && PAIR_OUT[a].style == MODE_PECL)
      else $error("enabled pair not driving");
    off_quiet_a: assert property (!PAIR_OUT[a].oe |-> !PAIR_OUT[a].true_p &&
        !PAIR_OUT[a].comp_p && PAIR_OUT[a].style == MODE_HIZ)
      else $error("floating pair shows a level");
    diff_comp_a: assert property (PAIR_OUT[a].oe && PAIR_OUT[a].style != MODE_CMOS
        |-> PAIR_OUT[a].comp_p != PAIR_OUT[a].true_p)
      else $error("differential pair not complementary");
  end

  low_cmos_a: assert property (st_ff.mode[0] == MODE_CMOS && st_ff.out_en[0]
      |=> !PAIR_OUT[0].oe)
    else $error("pair zero drove in cmos style");

  cmos_style_a: assert property (st_ff.out_en[3] && st_ff.mode[3] == MODE_CMOS
      |=> PAIR_OUT[3].oe && PAIR_OUT[3].style == MODE_CMOS)
    else $error("pair three cmos style not driven");

  pol_invert_a: assert property (st_ff.out_en[3] && st_ff.mode[3] == MODE_LVDS
      |=> PAIR_OUT[3].true_p == ($past(st_ff.sync2[3]) ^ $past(st_ff.pol3)))
    else $error("pair three polarity wrong");

  se_phase_a: assert property (st_ff.out_en[3] && st_ff.mode[3] == MODE_CMOS
      |=> PAIR_OUT[3].comp_p == (PAIR_OUT[3].true_p ^ !$past(st_ff.se_same)))
    else $error("pair three single-ended phase wrong");

  rsvd_read_a: assert property (s_rsvd_rd |=> REG_RDATA_OUT == 8'h00)
    else $error("reserved byte read non-zero");

  div_refuse_a: assert property (s_bad_div0_wr |=> REG_REFUSED_OUT &&
      st_ff.div0 == $past(st_ff.div0))
    else $error("illegal divider code accepted");

  div3_floor_a: assert property (st_ff.div3 >= DIV3_MIN &&
      DIV_RATIO_OUT.r3 == {st_ff.div3, 1'b0})
    else $error("pair three divider below floor or ratio not doubled");

  div_map_a: assert property (s_hi_wr_ok |=>
      st_ff.div3[DIV3_W-1 -: DIV3_HI_W] == $past(REG_REQ_IN.wdata[DIV3_HI_W-1:0]) &&
      !REG_REFUSED_OUT)
    else $error("high divider byte not stored");

  // pairs zero to two never invert, whatever the polarity bit holds
  low_pol_a: assert property (st_ff.out_en[0] && st_ff.mode[0] == MODE_LVDS
      |=> PAIR_OUT[0].true_p == $past(st_ff.sync2[0]))
    else $error("pair zero clock inverted");

  // bank checks: stores, read-back and divider floors
  pol_write_a: assert property (s_pol_wr |=>
      st_ff.pol3 == $past(REG_REQ_IN.wdata[POL_BIT]))
    else $error("polarity bit not stored");

  en_write_a: assert property (s_en_wr |=>
      st_ff.out_en == $past(REG_REQ_IN.wdata[EN_LSB +: EN_W]))
    else $error("enable byte not stored");

  en_read_a: assert property (REG_REQ_IN.rd && REG_REQ_IN.addr == ADR_OUT_EN |=>
      REG_RDATA_OUT[BYTE_W-1:EN_W] == '0 &&
      REG_RDATA_OUT[EN_LSB +: EN_W] == $past(st_ff.out_en))
    else $error("enable byte read back wrong");

  mode_read_a: assert property (s_mode32_rd |=>
      REG_RDATA_OUT[MODE_HI_LSB +: MODE_W] == $past(st_ff.mode[CMOS_PAIR]))
    else $error("pair three style reads back wrong");

  div3_refuse_a: assert property (s_bad_div3_wr |=> REG_REFUSED_OUT &&
      st_ff.div3 == $past(st_ff.div3))
    else $error("pair three divider took a value below three");

  // the refusal logic must keep every stored low code legal
  div_legal_a: assert property (lo_div_ok(st_ff.div0) && lo_div_ok(st_ff.div1) &&
      lo_div_ok(st_ff.div2))
    else $error("low divider holds an illegal code");

endmodule // codc_top

// >>> test/codc_rx_model.sv
`timescale 1ns/1ps
module codc_rx_model (
  input  wire logic                                   clk_in,  // system clock
  input  wire codc_pkg::codc_pin_s [codc_pkg::NUM_PAIRS-1:0] pair_in, // pairs from block
  output logic [codc_pkg::NUM_PAIRS-1:0]              lvl_out, // level each receiver sees
  output logic [codc_pkg::NUM_PAIRS-1:0]              on_out   // line is driven
);
  import codc_pkg::*;
  logic [NUM_PAIRS-1:0] float_ff = 4'b0101; // wander of an undriven line

  // a floating line keeps no level, so show one that flips every cycle
  always @(posedge clk_in) begin
    float_ff <= ~float_ff;
  end

  // receivers follow the true pin only while the pair is driven
  always_comb begin
    for (int i = 0; i < NUM_PAIRS; i++) begin
      on_out[i]  = pair_in[i].oe;
      lvl_out[i] = pair_in[i].oe ? pair_in[i].true_p : float_ff[i];
    end
  end
endmodule // codc_rx_model

// >>> test/codc_top_test.sv
`timescale 1ns/1ps
module codc_top_test;
  import codc_pkg::*;
  typedef struct packed {
    codc_addr_t a;
    logic [7:0] d;
    logic [7:0] rd;
    logic       rf;
  } codc_row_s;
  // write rows: address, data, read-back, refusal pulse
  localparam codc_row_s ROWS [0:17] = '{
    '{16'h003F, 8'h02, 8'h03, 1'b1}, '{16'h003F, 8'h06, 8'h06, 1'b0},
    '{16'h003F, 8'h07, 8'h06, 1'b1}, '{16'h0042, 8'hA0, 8'hA0, 1'b0},
    '{16'h0042, 8'hA1, 8'hA0, 1'b1}, '{16'h0045, 8'h08, 8'h08, 1'b0},
    '{16'h0045, 8'h09, 8'h08, 1'b1}, '{16'h0045, 8'hA2, 8'h08, 1'b1},
    '{16'h003F, 8'h03, 8'h03, 1'b0}, '{16'h004A, 8'h03, 8'h03, 1'b0},
    '{16'h0049, 8'h00, 8'h00, 1'b0}, '{16'h0048, 8'h00, 8'h00, 1'b0},
    '{16'h004A, 8'h02, 8'h03, 1'b1}, '{16'h004A, 8'h00, 8'h03, 1'b1},
    '{16'h0048, 8'h01, 8'h01, 1'b0}, '{16'h0050, 8'h55, 8'h00, 1'b0},
    '{16'h003B, 8'h00, 8'h00, 1'b0}, '{16'h0040, 8'h00, 8'h00, 1'b0}};
  localparam codc_addr_t RST_A [0:7] = '{16'h0039, 16'h003A, 16'h003D, 16'h003E,
                                         16'h003F, 16'h0048, 16'h0049, 16'h004A};
  localparam logic [7:0] RST_V [0:7] = '{8'h00, 8'h00, 8'h22, 8'h22,
                                         8'h03, 8'h02, 8'h00, 8'h02};
  logic                 clk_in = 1'b0;
  logic                 resetn_in;
  codc_req_s            req;
  logic [7:0]           rdata;
  logic                 refused;
  logic [NUM_PAIRS-1:0] src;
  codc_pin_s [3:0]      pairs;
  codc_div_s            div;
  logic [3:0]           rx_lvl;
  logic [3:0]           rx_on;
  logic                 ok;
  int                   error_cnt = 0;
  int                   n_tests = 0;

  always #10 clk_in = ~clk_in;

  codc_top codc_top_inst (
    .CLK_IN(clk_in), .RESETN_IN(resetn_in), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
    .REG_REFUSED_OUT(refused), .SRC_CLK_IN(src), .PAIR_OUT(pairs), .DIV_RATIO_OUT(div));
  codc_rx_model codc_rx_model_inst (
    .clk_in(clk_in), .pair_in(pairs), .lvl_out(rx_lvl), .on_out(rx_on));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one request held for one taking edge; answer sampled just after it
  task automatic access(input logic w, input codc_addr_t a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
  endtask

  // pins settle within sync plus drive flops
  task automatic pin3(input logic t, input logic c);
    repeat (4) @(posedge clk_in);
    #1;
    check("pair3 true", pairs[3].true_p, t);
    check("pair3 comp", pairs[3].comp_p, c);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200_000;
    error_cnt++;
    $display("ERROR watchdog expired");
    print_verdict();
  end

  initial begin
    req = '0;
    src = '0;
    resetn_in = 1'b0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    // divider codes: legal, illegal and pair three byte by byte, then unmapped and reserved bytes
    foreach (ROWS[k]) begin
      access(1'b1, ROWS[k].a, ROWS[k].d);
      check("refused", refused, ROWS[k].rf);
      access(1'b0, ROWS[k].a, 8'h00);
      check("rdata", rdata, ROWS[k].rd);
    end
    check("ratio0", div.r0, 8'h03);
    check("ratio1", div.r1, 8'hA0);
    check("ratio2", div.r2, 8'h08);
    check("ratio3", div.r3, 19'h2_0006);
    $display("test divider rows done");
    // second reset in mid-run, with every pair driving before it
    access(1'b1, ADR_OUT_EN, 8'h0F);
    @(posedge clk_in);
    #1;
    check("pre-reset oe", pairs[0].oe, 1'b1);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    for (int i = 0; i < NUM_PAIRS; i++) check("reset oe", pairs[i].oe, 1'b0);
    check("reset ratio1", div.r1, 8'h03);
    check("reset ratio3", div.r3, 19'h4_0004);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (RST_A[k]) begin
      access(1'b0, RST_A[k], 8'h00);
      check("reset rdata", rdata, RST_V[k]);
    end
    $display("test reset done");
    // every style code on every pair, all pairs enabled
    access(1'b1, ADR_OUT_EN, 8'h0F);
    @(posedge clk_in);
    src <= 4'hF;
    for (int c = 0; c < 8; c++) begin
      access(1'b1, ADR_MODE32, {c[2:0], 1'b0, c[2:0], 1'b0});
      access(1'b1, ADR_MODE10, {c[2:0], 1'b0, c[2:0], 1'b0});
      repeat (4) @(posedge clk_in);
      #1;
      for (int i = 0; i < 4; i++) begin
        ok = (c == 1 || c == 2 || c == 4 || (i == 3 && c == 3));
        check("oe", pairs[i].oe, ok);
        check("style", pairs[i].style, ok ? c : 0);
        check("true", pairs[i].true_p, ok);
        check("comp", pairs[i].comp_p, 1'b0);
        check("receiver", rx_on[i], ok);
        if (ok) check("rx level", rx_lvl[i], 1'b1);
      end
    end
    $display("test styles done");
    // pair three polarity and single-ended phase
    access(1'b1, ADR_MODE32, 8'h42);
    access(1'b1, ADR_POL, 8'h08);
    pin3(1'b0, 1'b1);
    access(1'b1, ADR_MODE32, 8'h72);
    pin3(1'b0, 1'b0);
    access(1'b1, ADR_POL, 8'h00);
    pin3(1'b1, 1'b1);
    access(1'b1, ADR_MODE32, 8'h62);
    pin3(1'b1, 1'b0);
    access(1'b1, ADR_OUT_EN, 8'h07);
    pin3(1'b0, 1'b0);
    check("pair3 off", pairs[3].oe, 1'b0);
    $display("test pair three done");
    print_verdict();
  end
endmodule // codc_top_test
